// ### core/rtg_pkg.sv
// What this block does
// - Display ends at display end plus 18
// - Border ends at border end plus 12
// - Cursor start is any pixel, plus 17
// - Cursor lasts 32 pixels, 16 in micro mode
// - Cursor start stays on whole pixel boundary
// - Odd field vertical sync at interlace offset
// - Counter preset test write loads horizontal counter
// - Load-all test write loads every horizontal register
// - Vertical cycle holds frame rasters minus 2
// - Vertical sync width holds rasters minus 1
// - Vertical border start holds rasters minus 1
// - Vertical cycle spans display plus flyback
// - Horizontal cycle holds pixels minus 8
// - Horizontal sync width holds pixels minus 8
package rtg_pkg;

  localparam int RTG_HW = 14;
  localparam int RTG_VW = 13;
  localparam int RTG_IW = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] RTG_IDX_HORIZ_CYCLE = 8'h80;
  localparam logic [7:0] RTG_IDX_HORIZ_SYNC_WIDTH = 8'h81;
  localparam logic [7:0] RTG_IDX_HORIZ_BORDER_START = 8'h82;
  localparam logic [7:0] RTG_IDX_HORIZ_DISPLAY_START = 8'h83;
  localparam logic [7:0] RTG_IDX_HORIZ_DISPLAY_END = 8'h84;
  localparam logic [7:0] RTG_IDX_HORIZ_BORDER_END = 8'h85;
  localparam logic [7:0] RTG_IDX_HORIZ_CURSOR_START = 8'h86;
  localparam logic [7:0] RTG_IDX_HORIZ_INTERLACE_OFFSET = 8'h87;
  localparam logic [7:0] RTG_IDX_HORIZ_COUNTER_PRESET_TEST = 8'h88;
  localparam logic [7:0] RTG_IDX_HORIZ_ALL_REGS_LOAD_TEST = 8'h8c;
  localparam logic [7:0] RTG_IDX_VERT_CYCLE = 8'h90;
  localparam logic [7:0] RTG_IDX_VERT_SYNC_WIDTH = 8'h91;
  localparam logic [7:0] RTG_IDX_VERT_BORDER_START = 8'h92;
  localparam logic [7:0] RTG_IDX_VERT_DISPLAY_START = 8'h93;
  localparam logic [7:0] RTG_IDX_VERT_DISPLAY_END = 8'h94;
  localparam logic [7:0] RTG_IDX_VERT_BORDER_END = 8'h95;
  localparam logic [7:0] RTG_IDX_CONTROL = 8'ha0;
  localparam logic [7:0] RTG_IDX_HSTATUS = 8'ha1;
  localparam logic [7:0] RTG_IDX_VSTATUS = 8'ha2;

  // Control and vertical status register fields
  localparam int RTG_CTRL_INTERLACE_BIT = 0;
  localparam int RTG_CTRL_MICRO_BIT = 1;
  localparam int RTG_VSTAT_FIELD_BIT = 13;

  // Programming offsets between register value and pixel or raster count
  localparam logic [13:0] RTG_H_CYCLE_OFS = 14'h0008;
  localparam logic [13:0] RTG_H_SYNC_OFS = 14'h0008;
  localparam logic [13:0] RTG_H_BORDER_OFS = 14'h000c;
  localparam logic [13:0] RTG_H_DISPLAY_OFS = 14'h0012;
  localparam logic [13:0] RTG_H_CURSOR_OFS = 14'h0011;
  localparam logic [12:0] RTG_V_CYCLE_OFS = 13'h0002;
  localparam logic [12:0] RTG_V_POS_OFS = 13'h0001;

  localparam logic [5:0] RTG_CURSOR_NORMAL_PIX = 6'h20;
  localparam logic [5:0] RTG_CURSOR_MICRO_PIX = 6'h10;

  localparam logic [13:0] RTG_H_RESET = 14'h0000;
  localparam logic [12:0] RTG_V_RESET = 13'h0000;

  typedef struct packed {
    logic [13:0] cycle;
    logic [13:0] sync_width;
    logic [13:0] border_start;
    logic [13:0] display_start;
    logic [13:0] display_end;
    logic [13:0] border_end;
    logic [13:0] cursor_start;
    logic [13:0] interlace_offset;
  } rtg_htime_t;

  typedef struct packed {
    logic [12:0] cycle;
    logic [12:0] sync_width;
    logic [12:0] border_start;
    logic [12:0] display_start;
    logic [12:0] display_end;
    logic [12:0] border_end;
  } rtg_vtime_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic border_en;
    logic display_en;
    logic cursor_en;
    logic field;
  } rtg_video_t;

endpackage

// ### core/rtg_timing.sv
`timescale 1ns/1ps
module rtg_timing
  import rtg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output rtg_video_t o_video
);

  typedef struct packed {
    rtg_htime_t ht;
    rtg_vtime_t vt;
    logic interlace;
    logic micro_pixel_mode;
    logic [13:0] hc;
    logic [12:0] vc;
    logic field;
    logic [5:0] cur_cnt;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    rtg_video_t video;
  } rtg_state_t;

  rtg_state_t s;
  rtg_state_t next_s;

  function automatic logic [13:0] hpos(input logic [13:0] v, input logic [13:0] o);
    hpos = 14'(v + o);
  endfunction

  function automatic logic [12:0] vpos(input logic [12:0] v, input logic [12:0] o);
    vpos = 13'(v + o);
  endfunction

  function automatic logic hwin(input logic [13:0] p, input logic [13:0] b, input logic [13:0] e);
    hwin = (p >= b) && (p < e);
  endfunction

  function automatic logic vwin(input logic [12:0] p, input logic [12:0] b, input logic [12:0] e);
    vwin = (p >= b) && (p < e);
  endfunction

  // Decoded positions in pixels and rasters from sync start
  logic [13:0] h_last;
  logic [13:0] h_sync_end;
  logic [13:0] h_bord_beg;
  logic [13:0] h_bord_end;
  logic [13:0] h_disp_beg;
  logic [13:0] h_disp_end;
  logic [13:0] h_cur_beg;
  logic [12:0] v_last;
  logic [12:0] v_sync_end;
  logic h_end;
  logic v_end;
  logic v_wrap;
  logic addr_ok;
  logic [7:0] a_idx;
  logic [31:0] rd_word;
  logic [13:0] wd14;
  logic [12:0] wd13;
  logic hpreset;
  logic hloadall;

  always_comb begin
    h_last = 14'(hpos(s.ht.cycle, RTG_H_CYCLE_OFS) - 14'h0001);
    h_sync_end = hpos(s.ht.sync_width, RTG_H_SYNC_OFS);
    h_bord_beg = hpos(s.ht.border_start, RTG_H_BORDER_OFS);
    h_bord_end = hpos(s.ht.border_end, RTG_H_BORDER_OFS);
    h_disp_beg = hpos(s.ht.display_start, RTG_H_DISPLAY_OFS);
    h_disp_end = hpos(s.ht.display_end, RTG_H_DISPLAY_OFS);
    h_cur_beg = hpos(s.ht.cursor_start, RTG_H_CURSOR_OFS);
    v_last = 13'(vpos(s.vt.cycle, RTG_V_CYCLE_OFS) - 13'h0001);
    v_sync_end = vpos(s.vt.sync_width, RTG_V_POS_OFS);
    h_end = (s.hc == h_last);
    v_end = (s.vc == v_last);
    // Even field ends in its last raster at the interlace offset, odd
    // field at the line end, so the even field is the shorter one
    if (s.interlace) begin
      v_wrap = v_end && (s.field ? h_end : (s.hc == s.ht.interlace_offset));
    end else begin
      v_wrap = v_end && h_end;
    end
    wd14 = i_hwdata[13:0];
    wd13 = i_hwdata[12:0];
    hpreset = s.wr_pend && (s.wr_idx == RTG_IDX_HORIZ_COUNTER_PRESET_TEST);
    hloadall = s.wr_pend && (s.wr_idx == RTG_IDX_HORIZ_ALL_REGS_LOAD_TEST);
  end

  // Bus decode; only whole-word accesses land in a register
  always_comb begin
    a_idx = i_haddr[9:2];
    addr_ok = (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'h0) && (i_hsize == 3'h2);
    rd_word = 32'h00000000;
    // Timing registers are write only and read as zero
    unique case (a_idx)
      RTG_IDX_CONTROL: begin
        rd_word[RTG_CTRL_INTERLACE_BIT] = s.interlace;
        rd_word[RTG_CTRL_MICRO_BIT] = s.micro_pixel_mode;
      end
      RTG_IDX_HSTATUS: begin
        rd_word[13:0] = s.hc;
      end
      RTG_IDX_VSTATUS: begin
        rd_word[12:0] = s.vc;
        rd_word[RTG_VSTAT_FIELD_BIT] = s.field;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.hready = 1'b1;
    next_s.hresp = 1'b0;
    next_s.wr_pend = 1'b0;
    if (i_hsel && i_htrans[1] && i_hready) begin
      next_s.wr_pend = i_hwrite && addr_ok;
      next_s.wr_idx = a_idx;
      if (!i_hwrite) begin
        next_s.hrdata = addr_ok ? rd_word : 32'h00000000;
      end
    end

    // Pixel and raster counters
    if (h_end) begin
      next_s.hc = RTG_H_RESET;
    end else begin
      next_s.hc = 14'(s.hc + 14'h0001);
    end
    if (v_wrap) begin
      next_s.vc = RTG_V_RESET;
      next_s.field = s.interlace ? ~s.field : 1'b0;
    end else if (h_end) begin
      next_s.vc = 13'(s.vc + 13'h0001);
    end

    // Cursor starts on a whole pixel; micro positioning is left to the image
    if (s.hc == h_cur_beg) begin
      next_s.cur_cnt = s.micro_pixel_mode ? RTG_CURSOR_MICRO_PIX : RTG_CURSOR_NORMAL_PIX;
    end else if (s.cur_cnt != 6'h00) begin
      next_s.cur_cnt = 6'(s.cur_cnt - 6'h01);
    end

    // Enables lag the counters by one clock
    next_s.video.hsync = (s.hc < h_sync_end);
    next_s.video.vsync = (s.vc < v_sync_end);
    next_s.video.display_en = hwin(s.hc, h_disp_beg, h_disp_end)
      && vwin(s.vc, vpos(s.vt.display_start, RTG_V_POS_OFS),
              vpos(s.vt.display_end, RTG_V_POS_OFS));
    next_s.video.border_en = hwin(s.hc, h_bord_beg, h_bord_end)
      && vwin(s.vc, vpos(s.vt.border_start, RTG_V_POS_OFS),
              vpos(s.vt.border_end, RTG_V_POS_OFS));
    // The start pixel is the first cursor pixel, so the width stays exact
    next_s.video.cursor_en = ((s.hc == h_cur_beg) || (s.cur_cnt > 6'h01))
      && vwin(s.vc, vpos(s.vt.display_start, RTG_V_POS_OFS),
              vpos(s.vt.display_end, RTG_V_POS_OFS));
    next_s.video.field = s.field;

    // Data phase of a write; a counter preset test write overrides the counter step
    if (s.wr_pend) begin
      unique case (s.wr_idx)
        RTG_IDX_HORIZ_CYCLE: next_s.ht.cycle = wd14;
        RTG_IDX_HORIZ_SYNC_WIDTH: next_s.ht.sync_width = wd14;
        RTG_IDX_HORIZ_BORDER_START: next_s.ht.border_start = wd14;
        RTG_IDX_HORIZ_DISPLAY_START: next_s.ht.display_start = wd14;
        RTG_IDX_HORIZ_DISPLAY_END: next_s.ht.display_end = wd14;
        RTG_IDX_HORIZ_BORDER_END: next_s.ht.border_end = wd14;
        RTG_IDX_HORIZ_CURSOR_START: next_s.ht.cursor_start = wd14;
        RTG_IDX_HORIZ_INTERLACE_OFFSET: next_s.ht.interlace_offset = wd14;
        RTG_IDX_HORIZ_COUNTER_PRESET_TEST: next_s.hc = wd14;
        RTG_IDX_HORIZ_ALL_REGS_LOAD_TEST: begin
          next_s.ht = {8{wd14}};
        end
        RTG_IDX_VERT_CYCLE: next_s.vt.cycle = wd13;
        RTG_IDX_VERT_SYNC_WIDTH: next_s.vt.sync_width = wd13;
        RTG_IDX_VERT_BORDER_START: next_s.vt.border_start = wd13;
        RTG_IDX_VERT_DISPLAY_START: next_s.vt.display_start = wd13;
        RTG_IDX_VERT_DISPLAY_END: next_s.vt.display_end = wd13;
        RTG_IDX_VERT_BORDER_END: next_s.vt.border_end = wd13;
        RTG_IDX_CONTROL: begin
          next_s.interlace = i_hwdata[RTG_CTRL_INTERLACE_BIT];
          next_s.micro_pixel_mode = i_hwdata[RTG_CTRL_MICRO_BIT];
        end
        default: begin
          next_s.wr_pend = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.hready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_hrdata = s.hrdata;
  assign o_hreadyout = s.hready;
  assign o_hresp = s.hresp;
  assign o_video = s.video;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_HC_WRAP: assert property (h_end && !s.wr_pend |=> s.hc == 14'h0000)
    else $error("horizontal counter did not wrap at line end");

  AST_HC_PRESET: assert property (hpreset |=> s.hc == $past(wd14))
    else $error("counter preset write not loaded");

  AST_LOAD_ALL: assert property (hloadall |=> s.ht.cycle == $past(wd14)
      && s.ht.cursor_start == $past(wd14) && s.ht.interlace_offset == $past(wd14))
    else $error("load-all write missed a horizontal register");

  // A write may move a sync end under a running count; that edge is not a sync start
  AST_HSYNC_START: assert property ($rose(s.video.hsync) && !$past(s.wr_pend, 2)
      |-> $past(s.hc) == 14'h0000)
    else $error("horizontal sync rose away from counter zero");

  AST_VSYNC_START: assert property ($rose(s.video.vsync) && !$past(s.wr_pend, 2)
      |-> $past(s.vc) == 13'h0000)
    else $error("vertical sync rose away from raster zero");

  AST_CURSOR_LEN: assert property (s.hc == h_cur_beg
      && !s.micro_pixel_mode && !s.wr_pend
      |=> s.cur_cnt == 6'h20 ##16 s.cur_cnt == 6'h10)
    else $error("cursor width in normal mode wrong");

  AST_DISPLAY_WIN: assert property (s.video.display_en && !$past(s.wr_pend)
      |-> $past(s.hc) >= h_disp_beg && $past(s.hc) < h_disp_end)
    else $error("display enable outside its window");

  AST_BORDER_WIN: assert property (s.video.border_en && !$past(s.wr_pend)
      |-> $past(s.hc) >= h_bord_beg && $past(s.hc) < h_bord_end)
    else $error("border enable outside its window");

  AST_VWRAP: assert property (!s.interlace && v_end && h_end && !s.wr_pend
      |=> s.vc == 13'h0000 && !s.field)
    else $error("raster counter did not wrap at frame end");

  AST_ODD_FIELD: assert property (s.interlace && !s.field && v_end
      && s.hc == s.ht.interlace_offset && !s.wr_pend |=> s.field && s.vc == 13'h0000)
    else $error("odd field did not start at interlace offset");

endmodule

// ### dv/rtg_monitor.sv
`timescale 1ns/1ps
// Stands in for the display: it times every line and frame from the sync edges
module rtg_monitor
  import rtg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire rtg_video_t i_video,
  output logic [15:0] o_line,
  output logic [15:0] o_frame,
  output logic [15:0] o_vs,
  output logic [15:0] o_frames,
  output logic [15:0] o_len [4],
  output logic [15:0] o_at [4]
);
  logic [15:0] pos, lines, vs;
  logic [15:0] run [4];
  logic [3:0] s, ps;
  logic pvs, hrise, vrise;
  assign s = {i_video.cursor_en, i_video.border_en, i_video.display_en, i_video.hsync};
  assign hrise = s[0] & ~ps[0];
  assign vrise = i_video.vsync & ~pvs;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ps <= 4'h0;
      pvs <= 1'b0;
      pos <= 16'h0;
      lines <= 16'h0;
      vs <= 16'h0;
      o_frames <= 16'h0;
      run <= '{default: 16'h0};
    end else begin
      ps <= s;
      pvs <= i_video.vsync;
      pos <= hrise ? 16'h1 : pos + 16'h1;
      if (hrise) begin
        o_line <= pos;
        lines <= vrise ? 16'h1 : lines + 16'h1;
        vs <= vrise ? 16'h1 : vs + 16'(i_video.vsync);
      end
      if (vrise) begin
        o_frame <= lines;
        o_vs <= vs;
        o_frames <= o_frames + 16'h1;
      end
      // Lines without an enable keep the last measured width
      for (int i = 0; i < 4; i++) begin
        if (s[i] && !ps[i]) o_at[i] <= pos;
        if (hrise && (i == 0 || run[i] != 16'h0)) o_len[i] <= run[i];
        run[i] <= hrise ? 16'(s[i]) : run[i] + 16'(s[i]);
      end
    end
  end
endmodule

// ### dv/raster_timing_generator_tb.sv
`timescale 1ns/1ps
module raster_timing_generator_tb;
  import rtg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_hsel = 1'b1;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_hresp;
  rtg_video_t o_video;
  logic [15:0] m_line, m_frame, m_vs, m_frames;
  logic [15:0] m_len [4];
  logic [15:0] m_at [4];
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] a, b;
  logic f;
  localparam logic [7:0] IDX [11] = '{RTG_IDX_HORIZ_CYCLE, RTG_IDX_HORIZ_SYNC_WIDTH,
    RTG_IDX_HORIZ_BORDER_START, RTG_IDX_HORIZ_DISPLAY_START, RTG_IDX_HORIZ_DISPLAY_END,
    RTG_IDX_HORIZ_BORDER_END, RTG_IDX_HORIZ_CURSOR_START, RTG_IDX_VERT_CYCLE,
    RTG_IDX_VERT_SYNC_WIDTH, RTG_IDX_VERT_DISPLAY_START, RTG_IDX_VERT_DISPLAY_END};
  // 64 px line, 10 px sync, border 12..26, display 20..24, cursor at 20, 4 rasters
  localparam logic [31:0] VAL [11] = '{32'h38, 32'h2, 32'h0, 32'h2, 32'h6, 32'he, 32'h3,
    32'h2, 32'h1, 32'h0, 32'h3};
  rtg_timing i_rtg_timing (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_video(o_video));
  rtg_monitor i_rtg_monitor (.i_mclk(i_mclk), .i_rst(i_rst), .i_video(o_video),
    .o_line(m_line), .o_frame(m_frame), .o_vs(m_vs), .o_frames(m_frames), .o_len(m_len),
    .o_at(m_at));
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 100);
    if (o_hreadyout !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // Whole-word single transfer; the data phase is held until hready is seen
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] d);
    i_haddr <= {22'h0, idx, 2'h0};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    wait_ready();
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_ready();
    d = o_hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, idx, v, d);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    bus(1'b0, idx, 32'h0, d);
  endtask
  task automatic wait_frames(input int k);
    int n;
    logic [15:0] st;
    n = 0;
    st = m_frames;
    while (int'(m_frames - st) < k && n < 5000) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 5000) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    check(32'(o_video), 32'h0);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    check(32'(o_hreadyout), 32'h1);
    check(32'(o_hresp), 32'h0);
    wr(RTG_IDX_CONTROL, 32'h2);
    rd(RTG_IDX_CONTROL, a);
    check(a, 32'h2);
    wr(8'hc0, 32'h5a5a);
    rd(8'hc0, a);
    check(a, 32'h0);
    wr(RTG_IDX_CONTROL, 32'h0);
    for (int i = 0; i < 11; i++) begin
      wr(IDX[i], VAL[i]);
    end
    // No border wanted vertically: border window matches the display window
    wr(RTG_IDX_VERT_BORDER_START, 32'h0);
    wr(RTG_IDX_VERT_BORDER_END, 32'h3);
    rd(RTG_IDX_HORIZ_CYCLE, a);
    check(a, 32'h0);
    wait_frames(2);
    check(32'(m_line), 32'd64);
    check(32'(m_len[0]), 32'd10);
    check(32'(m_at[1]), 32'd20);
    check(32'(m_len[1]), 32'd4);
    check(32'(m_at[2]), 32'd12);
    check(32'(m_len[2]), 32'd14);
    check(32'(m_at[3]), 32'd20);
    // Full automatic width; a narrower cursor is padded with transparent pattern
    check(32'(m_len[3]), 32'd32);
    check(32'(m_frame), 32'd4);
    check(32'(m_vs), 32'd2);
    check(32'(o_video.field), 32'h0);
    wr(RTG_IDX_CONTROL, 32'h2);
    wait_frames(2);
    check(32'(m_len[3]), 32'd16);
    check(32'(m_at[3]), 32'd20);
    // Interlaced: a 4 raster frame and a 28 pixel odd field offset in the 64 px line
    wr(RTG_IDX_HORIZ_INTERLACE_OFFSET, 32'h1c);
    wr(RTG_IDX_VERT_CYCLE, 32'h2);
    wr(RTG_IDX_CONTROL, 32'h1);
    wait_frames(2);
    f = o_video.field;
    wait_frames(1);
    check(32'(o_video.field), 32'(!f));
    rd(RTG_IDX_HSTATUS, a);
    rd(RTG_IDX_HSTATUS, b);
    check(b, (a + 32'h2) % 32'd64);
    wr(RTG_IDX_HORIZ_COUNTER_PRESET_TEST, 32'h2a);
    rd(RTG_IDX_HSTATUS, a);
    check(a, 32'h2a);
    wr(RTG_IDX_HORIZ_ALL_REGS_LOAD_TEST, 32'h0);
    // The count sits past the new, shorter line end; restart it at zero
    wr(RTG_IDX_HORIZ_COUNTER_PRESET_TEST, 32'h0);
    rd(RTG_IDX_HSTATUS, a);
    rd(RTG_IDX_HSTATUS, b);
    check(b, (a + 32'h2) % 32'd8);
    check(32'(o_video.hsync), 32'h1);
    check(32'(o_video.display_en), 32'h0);
    report_and_stop();
  end
endmodule
